// file: design/mstop_core.sv
// mstop_core: stop sequencing, tach output and supply current cap
//
// Function
// - stop mode field selects stop behaviour
// - coast: all six switches off at once
// - recirc: partial off for decay, then all
// - recirc side from high bit of phase pattern
// - low-side brake after slowing to entry
// - high-side brake after slowing to entry
// - below entry speed: brake immediately
// - after brake duration all switches off
// - brake pin: slow, hold low-sides on
// - spin-down: ramp target, then all off
// - align: fixed DC pattern for brake duration
// - brake pin may request align brake
// - align angle from config or last commutation
// - tach persist: driving only or until floor
// - tach divided per N electrical cycles
// - closed loop tach follows driving speed
// - motor lock holds tach high
// - open loop policy 00: follow driving
// - open loop policy 01: held high
// - policy 10: follow first start only
// - cap limits speed reference when on
// - supply current estimated from phases
// - cap active flag reports limiting
`timescale 1ns/1ps
`default_nettype none

module mstop_core
	import mstop_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        brake_pin,
	input  wire logic        motor_lock,
	input  wire logic        open_loop,
	input  wire logic        elec_tick,
	input  wire logic [15:0] motor_speed,
	input  wire logic [15:0] back_emf,
	input  wire logic [15:0] speed_cmd,
	input  wire logic [2:0]  comm_angle,
	input  wire logic [2:0]  phase_pattern,
	input  wire logic [15:0] phase_current,
	input  wire logic [15:0] phase_voltage,
	input  wire logic [15:0] supply_voltage,
	output logic      [5:0]  gate_on,
	output logic             align_active,
	output logic      [2:0]  align_angle,
	output logic      [15:0] speed_ref,
	output logic             tach_output
);

	////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [1:0] brk_s_q;
	logic       brk_d1_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			brk_s_q  <= 2'h0;
			brk_d1_q <= 1'b0;
		end else begin
			brk_s_q  <= {brk_s_q[0], brake_pin};
			brk_d1_q <= brk_s_q[1];
		end
	end
	wire logic brk_lvl = brk_d1_q;

	////////////////////////////////////////////////////////////////////
	// registers
	logic [31:0] stopcfg_q;
	logic [31:0] tachcfg_q;
	logic [31:0] cap_q;
	logic        ack_q;
	logic        start_p;
	logic        stop_p;
	logic        running_q;
	logic        cap_active_q;
	mstop_state_type st_q;

	wire logic [3:0] widx   = mstop_word(avs_address);
	wire logic       req    = (avs_read | avs_write) & ~ack_q;
	wire logic       wr_en  = avs_write & ack_q;

	wire logic [2:0]  mode_f   = stopcfg_q[F_MODE +: 3];
	wire logic [11:0] brkdur_f = stopcfg_q[F_BRKDUR +: 12];
	wire logic [15:0] brkspd_f = stopcfg_q[F_BRKSPD +: 16];
	wire logic [3:0]  tdiv_f   = tachcfg_q[F_TDIV +: 4];
	wire logic        persist  = tachcfg_q[F_PERSIST];
	wire logic [1:0]  olp_f    = tachcfg_q[F_OLP +: 2];
	wire logic [7:0]  floor_f  = tachcfg_q[F_FLOOR +: 8];
	wire logic [15:0] spin_f   = tachcfg_q[F_SPIN +: 16];
	wire logic [15:0] capval_f = cap_q[15:0];
	wire logic        capon_f  = cap_q[F_CAPON];
	wire logic        alsel_f  = cap_q[F_ALSEL];
	wire logic [2:0]  alang_f  = cap_q[F_ALANG +: 3];

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stopcfg_q <= RST_STOPCFG;
			tachcfg_q <= RST_TACHCFG;
			cap_q     <= RST_CAP;
			ack_q     <= 1'b0;
		end else begin
			ack_q <= req;
			if (wr_en && widx == REG_STOPCFG)
				stopcfg_q <= avs_writedata;
			if (wr_en && widx == REG_TACHCFG)
				tachcfg_q <= avs_writedata;
			if (wr_en && widx == REG_CAP)
				cap_q <= avs_writedata;
		end
	end
	assign start_p = wr_en && widx == REG_CTRL && avs_writedata[0];
	assign stop_p  = wr_en && widx == REG_CTRL && avs_writedata[1];

	wire logic [31:0] status_w = {24'h0, cap_active_q, running_q,
		tach_output, 2'h0, st_q};
	wire logic [31:0] rd_mux =
		(widx == REG_STOPCFG) ? stopcfg_q :
		(widx == REG_TACHCFG) ? tachcfg_q :
		(widx == REG_CAP)     ? cap_q :
		(widx == REG_STATUS)  ? status_w :
		(widx == REG_SPEED)   ? {16'h0, speed_ref} : 32'h0;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			avs_readdata <= 32'h0;
		else if (req && avs_read)
			avs_readdata <= rd_mux;
	end
	assign avs_waitrequest = ~ack_q;

	////////////////////////////////////////////////////////////////////
	// supply current estimate and cap
	// power balance estimate
	wire logic [31:0] pwr   = phase_current * phase_voltage;
	wire logic [15:0] vsup  = (supply_voltage == 16'h0) ? 16'h1
		: supply_voltage;
	wire logic [15:0] i_est = 16'(pwr / {16'h0, vsup});
	wire logic        limiting = capon_f && i_est > capval_f;
	logic      [15:0] cap_ref_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cap_ref_q    <= 16'h0;
			cap_active_q <= 1'b0;
		end else begin
			cap_active_q <= limiting;
			if (limiting && cap_ref_q != 16'h0)
				cap_ref_q <= cap_ref_q - 16'h1;
			else if (!limiting)
				cap_ref_q <= speed_cmd;
		end
	end

	////////////////////////////////////////////////////////////////////
	// stop sequencer
	logic [31:0] tmr_q;
	logic        recirc_hs_q;
	logic        pin_align_q;
	logic [2:0]  stop_pat_q;
	wire logic [31:0] brk_cyc = 32'(brkdur_f) * 32'(BRK_UNIT_CYC);
	wire logic   tmr_done = (tmr_q == 32'h0);
	wire logic   is_brake = mode_f == STOP_LS_BRAKE
		|| mode_f == STOP_HS_BRAKE;
	wire logic   pin_align = mode_f == STOP_ALIGN;
	wire logic [15:0] target = (mode_f == STOP_SPIN) ? spin_f : brkspd_f;
	wire logic   slow_ok   = motor_speed <= target;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_q        <= MS_HIZ;
			tmr_q       <= 32'h0;
			recirc_hs_q <= 1'b0;
			stop_pat_q  <= 3'h0;
			pin_align_q <= 1'b0;
			running_q   <= 1'b0;
			speed_ref   <= 16'h0;
		end else begin
			if (!tmr_done)
				tmr_q <= tmr_q - 32'h1;
			case (st_q)
			MS_RUN: begin
				speed_ref <= capon_f ? cap_ref_q : speed_cmd;
				if (brk_lvl) begin
					st_q        <= MS_DECEL;
					pin_align_q <= pin_align;
				end else if (stop_p) begin
					pin_align_q <= 1'b0;
					if (mode_f == STOP_RECIRC) begin
						st_q        <= MS_RECIRC;
						recirc_hs_q <= phase_pattern[2];
						stop_pat_q  <= phase_pattern;
						tmr_q       <= 32'(RECIRC_CYC);
					end else if (is_brake || mode_f == STOP_SPIN) begin
						st_q  <= (slow_ok && is_brake) ? MS_BRAKE
							: MS_DECEL;
						tmr_q <= brk_cyc;
					end else if (mode_f == STOP_ALIGN) begin
						st_q  <= MS_BRAKE;
						tmr_q <= brk_cyc;
					end else begin
						st_q      <= MS_HIZ;
						running_q <= 1'b0;
					end
				end
			end
			MS_DECEL: begin
				if (speed_ref > target)
					speed_ref <= speed_ref - 16'h1;
				if (slow_ok || speed_ref <= target) begin
					if (brk_lvl)
						st_q <= MS_PINBRK;
					else if (mode_f == STOP_SPIN) begin
						st_q      <= MS_HIZ;
						running_q <= 1'b0;
					end else begin
						st_q  <= MS_BRAKE;
						tmr_q <= brk_cyc;
					end
				end
			end
			MS_PINBRK: begin
				if (!brk_lvl) begin
					st_q      <= MS_HIZ;
					running_q <= 1'b0;
				end
			end
			MS_RECIRC, MS_BRAKE: begin
				if (tmr_done) begin
					st_q      <= MS_HIZ;
					running_q <= 1'b0;
				end
			end
			default: begin
				speed_ref <= 16'h0;
				if (start_p) begin
					st_q      <= MS_RUN;
					running_q <= 1'b1;
				end
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// gate pattern: {hs_a, hs_b, hs_c, ls_a, ls_b, ls_c}
	wire logic brk_align = (st_q == MS_BRAKE && mode_f == STOP_ALIGN)
		|| (st_q == MS_PINBRK && pin_align_q);
	wire logic [5:0] gate_d =
		(st_q == MS_RUN || st_q == MS_DECEL) ?
			{phase_pattern, ~phase_pattern} :
		(st_q == MS_RECIRC) ?
			(recirc_hs_q ? {stop_pat_q, 3'h0}
				: {3'h0, ~stop_pat_q}) :
		brk_align ? {1'b1, 2'h0, 1'b0, 2'h3} :
		(st_q == MS_PINBRK) ? 6'h07 :
		(st_q == MS_BRAKE && mode_f == STOP_HS_BRAKE) ? 6'h38 :
		(st_q == MS_BRAKE && mode_f == STOP_LS_BRAKE) ? 6'h07 : 6'h00;
	wire logic [2:0] ang_d = alsel_f ? comm_angle : alang_f;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			gate_on      <= 6'h00;
			align_active <= 1'b0;
			align_angle  <= 3'h0;
		end else begin
			gate_on      <= gate_d;
			align_active <= brk_align;
			align_angle  <= ang_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// tach output
	logic [3:0] tcnt_q;
	logic       first_q;
	logic       toggle_q;
	wire logic driving = (st_q == MS_RUN || st_q == MS_DECEL);
	wire logic tach_en = driving
		|| (persist && back_emf >= {8'h0, floor_f});
	wire logic ol_high = open_loop && (olp_f == OLP_HIGH
		|| (olp_f == OLP_FIRST && !first_q));
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tcnt_q      <= 4'h0;
			toggle_q    <= 1'b0;
			first_q     <= 1'b1;
			tach_output <= 1'b0;
		end else begin
			if (st_q == MS_RUN && !open_loop)
				first_q <= 1'b0;
			if (tach_en && elec_tick) begin
				if (tcnt_q >= tdiv_f) begin
					tcnt_q   <= 4'h0;
					toggle_q <= ~toggle_q;
				end else
					tcnt_q <= tcnt_q + 4'h1;
			end
			tach_output <= motor_lock || ol_high || (tach_en & toggle_q);
		end
	end

	////////////////////////////////////////////////////////////////////
	// assertions
	hiz_gates_a: assert property (@(posedge clock) disable iff (!rst_n)
		st_q == MS_HIZ |=> gate_on == 6'h00)
		else $error("gates on in Hi-Z");
	coast_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
		(st_q == MS_RUN && stop_p && !brk_lvl && mode_f == STOP_COAST)
		|=> st_q == MS_HIZ ##1 gate_on == 6'h00)
		else $error("coast did not go Hi-Z");
	ls_brake_a: assert property (@(posedge clock) disable iff (!rst_n)
		(st_q == MS_BRAKE && mode_f == STOP_LS_BRAKE) |=> gate_on == 6'h07)
		else $error("low-side brake pattern wrong");
	hs_brake_a: assert property (@(posedge clock) disable iff (!rst_n)
		(st_q == MS_BRAKE && mode_f == STOP_HS_BRAKE) |=> gate_on == 6'h38)
		else $error("high-side brake pattern wrong");
	fast_brake_a: assert property (@(posedge clock) disable iff (!rst_n)
		(st_q == MS_RUN && stop_p && !brk_lvl && is_brake && slow_ok)
		|=> st_q == MS_BRAKE)
		else $error("brake entry not immediate");
	pin_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		(st_q == MS_PINBRK && brk_lvl) |=> st_q == MS_PINBRK)
		else $error("pin brake released early");
	lock_tach_a: assert property (@(posedge clock) disable iff (!rst_n)
		motor_lock |=> tach_output)
		else $error("tach low during lock");
	cap_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
		limiting |=> cap_active_q)
		else $error("cap flag missing");
	bus_ack_a: assert property (@(posedge clock) disable iff (!rst_n)
		($rose(avs_read | avs_write)) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus answer not one cycle");
	cv_recirc: cover property (@(posedge clock) disable iff (!rst_n)
		st_q == MS_RECIRC ##1 st_q == MS_HIZ);
	cv_pinbrk: cover property (@(posedge clock) disable iff (!rst_n)
		st_q == MS_PINBRK);
	cv_align: cover property (@(posedge clock) disable iff (!rst_n)
		align_active);
	brake_end_a: assert property (@(posedge clock) disable iff (!rst_n)
		(st_q == MS_BRAKE && tmr_done) |=> st_q == MS_HIZ)
		else $error("brake did not end in Hi-Z");
	cv_spin: cover property (@(posedge clock) disable iff (!rst_n)
		st_q == MS_DECEL && mode_f == STOP_SPIN ##1 st_q == MS_HIZ);
	cv_hs_brake: cover property (@(posedge clock) disable iff (!rst_n)
		st_q == MS_BRAKE && mode_f == STOP_HS_BRAKE);

endmodule : mstop_core

`default_nettype wire

// file: design/mstop_pkg.sv
// mstop_pkg: register map, field codes and timing constants for motor stop block
package mstop_pkg;

	// register word indices (byte address divided by four)
	localparam logic [3:0]  REG_CTRL      = 4'h0;
	localparam logic [3:0]  REG_STOPCFG   = 4'h1;
	localparam logic [3:0]  REG_TACHCFG   = 4'h2;
	localparam logic [3:0]  REG_CAP       = 4'h3;
	localparam logic [3:0]  REG_STATUS    = 4'h4;
	localparam logic [3:0]  REG_SPEED     = 4'h5;

	// stop mode codes
	localparam logic [2:0]  STOP_COAST    = 3'h0;
	localparam logic [2:0]  STOP_RECIRC   = 3'h1;
	localparam logic [2:0]  STOP_LS_BRAKE = 3'h2;
	localparam logic [2:0]  STOP_HS_BRAKE = 3'h3;
	localparam logic [2:0]  STOP_SPIN     = 3'h4;
	localparam logic [2:0]  STOP_ALIGN    = 3'h5;

	// tach open loop policy codes
	localparam logic [1:0]  OLP_FOLLOW    = 2'h0;
	localparam logic [1:0]  OLP_HIGH      = 2'h1;
	localparam logic [1:0]  OLP_FIRST     = 2'h2;

	// field positions in the stop config register
	localparam int          F_MODE        = 0;
	localparam int          F_BRKDUR      = 4;
	localparam int          F_BRKSPD      = 16;
	// field positions in the tach config register
	localparam int          F_TDIV        = 0;
	localparam int          F_PERSIST     = 4;
	localparam int          F_OLP         = 5;
	localparam int          F_FLOOR       = 8;
	localparam int          F_SPIN        = 16;
	// field positions in the cap register
	localparam int          F_CAPON       = 31;
	localparam int          F_ALSEL       = 30;
	localparam int          F_ALANG       = 24;

	// reset values
	localparam logic [31:0] RST_STOPCFG   = 32'h0000_0000;
	localparam logic [31:0] RST_TACHCFG   = 32'h0000_0000;
	localparam logic [31:0] RST_CAP       = 32'h0000_0000;

	// brake duration unit: 1 ms per count
	localparam int          BRK_UNIT_NS   = 1000000;
	localparam int          CLK_NS        = 20;
	localparam int          BRK_UNIT_CYC  = BRK_UNIT_NS / CLK_NS;
	// recirculation decay interval: 10 us
	localparam int          RECIRC_NS     = 10000;
	localparam int          RECIRC_CYC    = RECIRC_NS / CLK_NS;

	typedef enum logic [2:0] {
		MS_RUN, MS_DECEL, MS_RECIRC, MS_BRAKE, MS_PINBRK, MS_HIZ
	} mstop_state_type;

	// avalon word address from byte address
	function automatic logic [3:0] mstop_word(input logic [5:0] a);
		return a[5:2];
	endfunction : mstop_word

endpackage : mstop_pkg

// file: dv/mstop_motor_model.sv
// mstop_motor_model: behavioural rotor feedback for the stop block
`timescale 1ns/1ps
`default_nettype none

module mstop_motor_model (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [15:0] speed_ref,
	output logic             elec_tick,
	output logic      [15:0] motor_speed,
	output logic      [15:0] back_emf,
	output logic      [2:0]  phase_pattern
);
	logic [2:0] tick_cnt_q;

	assign back_emf = motor_speed;

	// rotor slews one count a cycle, ticks every eighth cycle while turning
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			motor_speed   <= 16'h0000;
			tick_cnt_q    <= 3'h0;
			elec_tick     <= 1'b0;
			phase_pattern <= 3'h1;
		end else begin
			if (motor_speed < speed_ref)
				motor_speed <= motor_speed + 16'h0001;
			// undriven rotor coasts down eight times slower
			else if (motor_speed > speed_ref
				&& (speed_ref != 16'h0000 || tick_cnt_q == 3'h7))
				motor_speed <= motor_speed - 16'h0001;
			tick_cnt_q <= tick_cnt_q + 3'h1;
			elec_tick  <= (tick_cnt_q == 3'h7) && (motor_speed != 16'h0000);
			if (elec_tick)
				phase_pattern <= {phase_pattern[1:0], phase_pattern[2]};
		end
	end
endmodule : mstop_motor_model

`default_nettype wire

// file: dv/tb_top.sv
// tb_top: self-checking bench for the motor stop block
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import mstop_pkg::*;
;
	typedef struct {
		logic [2:0]  sel;
		logic [31:0] exp;
		logic [31:0] msk;
	} mstop_note_type;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	mstop_note_type notes[$];
	mstop_note_type n;
	string       names[5] = '{"readdata", "gate_on", "align", "tach", "gap"};
	logic        clock, rst_n, avs_read, avs_write, avs_waitrequest, probe;
	logic        brake_pin, motor_lock, open_loop, elec_tick;
	logic        align_active, tach_output;
	logic [5:0]  avs_address, gate_on;
	logic [31:0] avs_writedata, avs_readdata, v;
	logic [15:0] motor_speed, back_emf, speed_cmd, speed_ref;
	logic [15:0] phase_current, phase_voltage, supply_voltage;
	logic [2:0]  comm_angle, phase_pattern, align_angle, pat;
	logic [3:0]  divs[3] = '{4'h0, 4'h4, 4'hE};
	int          errors, n_compared, ticks, gap;

	mstop_core u_dut (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .brake_pin(brake_pin),
		.motor_lock(motor_lock), .open_loop(open_loop), .elec_tick(elec_tick),
		.motor_speed(motor_speed), .back_emf(back_emf), .speed_cmd(speed_cmd),
		.comm_angle(comm_angle), .phase_pattern(phase_pattern),
		.phase_current(phase_current), .phase_voltage(phase_voltage),
		.supply_voltage(supply_voltage), .gate_on(gate_on),
		.align_active(align_active), .align_angle(align_angle),
		.speed_ref(speed_ref), .tach_output(tach_output));
	mstop_motor_model u_motor (.clock(clock), .rst_n(rst_n),
		.speed_ref(speed_ref), .elec_tick(elec_tick),
		.motor_speed(motor_speed), .back_emf(back_emf),
		.phase_pattern(phase_pattern));

	initial clock = 1'b0;
	always #10 clock = ~clock;

	////////////////////////////////////////////////////////////////////////
	// watcher: takes the oldest note whenever a result appears
	always @(posedge clock) begin
		ticks <= ticks + (elec_tick ? 1 : 0);
		if ((avs_read === 1'b1 && avs_waitrequest === 1'b0) || probe) begin
			n = notes.pop_front();
			case (n.sel)
			3'h0: v = avs_readdata;
			3'h1: v = {26'h0, gate_on};
			3'h2: v = {28'h0, align_active, align_angle};
			3'h3: v = {31'h0, tach_output};
			default: v = gap;
			endcase
			n_compared++;
			if ((v & n.msk) !== (n.exp & n.msk)) begin
				errors++;
				$display("unexpected %s: expected %h seen %h", names[n.sel],
					n.exp & n.msk, v & n.msk);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test

	task automatic give_up();
		errors++;
		$display("unexpected wait: expected response seen none");
		stop_test();
	endtask : give_up

	task automatic bus(input logic wr, input logic [3:0] w, input logic [31:0] d);
		int i;
		@(posedge clock);
		avs_address   <= {w, 2'h0};
		avs_write     <= wr;
		avs_read      <= !wr;
		avs_writedata <= d;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 50);
		if (i >= 50)
			give_up();
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic rd(input logic [3:0] w, input logic [31:0] e, m);
		notes.push_back('{3'h0, e, m});
		bus(1'b0, w, 32'h0);
	endtask : rd

	task automatic chk(input logic [2:0] s, input logic [31:0] e);
		notes.push_back('{s, e, ALL});
		probe <= 1'b1;
		@(posedge clock);
		probe <= 1'b0;
	endtask : chk

	task automatic poll(input logic [2:0] s);
		for (int i = 0; i < 400; i++) begin
			rd(REG_STATUS, 32'h0, 32'h0);
			if (avs_readdata[2:0] === s)
				return;
		end
		give_up();
	endtask : poll

	// ticks between two tach edges
	task automatic tach_gap(input logic [31:0] e);
		logic t;
		int   i, t0;
		for (int k = 0; k < 3; k++) begin
			t0 = ticks;
			t = tach_output;
			for (i = 0; i < 600 && tach_output === t; i++)
				@(posedge clock);
			if (i >= 600)
				give_up();
		end
		gap = ticks - t0;
		chk(3'h4, e);
	endtask : tach_gap

	initial begin
		repeat (90000) @(posedge clock);
		give_up();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		{avs_read, avs_write, probe, brake_pin, motor_lock, open_loop} = 6'h00;
		avs_address = 6'h00;
		avs_writedata = 32'h0;
		void'($urandom(19));
		speed_cmd = 16'h0010 + 16'($urandom_range(100));
		comm_angle = 3'($urandom_range(7));
		phase_current = 16'($urandom_range(15));
		phase_voltage = 16'($urandom_range(15));
		supply_voltage = 16'h1000 + 16'($urandom_range(255));
		rst_n = 1'b0;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		rd(REG_STOPCFG, RST_STOPCFG, ALL);
		rd(REG_TACHCFG, RST_TACHCFG, ALL);
		rd(REG_CAP, RST_CAP, ALL);
		bus(1'b1, 4'hF, ALL);
		bus(1'b1, REG_STATUS, 32'h0);
		rd(4'hF, 32'h0, ALL);
		rd(REG_STATUS, 32'h5, 32'h7);
		// every stop code, brake entry speed above rotor
		for (int m = 0; m < 8; m++) begin
			bus(1'b1, REG_STOPCFG, {16'hFFFF, 13'h0, m[2:0]});
			rd(REG_STOPCFG, {16'hFFFF, 13'h0, m[2:0]}, ALL);
			bus(1'b1, REG_CTRL, 32'h1);
			poll(3'h0);
			bus(1'b1, REG_CTRL, 32'h2);
			pat = phase_pattern;
			if (m == 1) begin
				rd(REG_STATUS, 32'h2, 32'h7);
				chk(3'h1, pat[2] ? {26'h0, pat, 3'h0} : {29'h0, ~pat});
			end
			poll(3'h5);
			chk(3'h1, 32'h0);
		end
		// pin brake: low-side hold, then align from both angle sources
		for (int k = 0; k < 3; k++) begin
			bus(1'b1, REG_STOPCFG, (k == 0) ? 32'hFFFF_0002 : 32'hFFFF_0005);
			bus(1'b1, REG_CAP, {1'b0, k == 2, 3'h0, 3'h6, 24'h0});
			bus(1'b1, REG_CTRL, 32'h1);
			poll(3'h0);
			brake_pin <= 1'b1;
			if (k == 0) begin
				poll(3'h4);
				chk(3'h1, 32'h07);
			end else begin
				for (int i = 0; i < 100 && align_active !== 1'b1; i++)
					@(posedge clock);
				if (align_active !== 1'b1)
					give_up();
				chk(3'h2, {29'h1, (k == 2) ? comm_angle : 3'h6});
			end
			brake_pin <= 1'b0;
			repeat (4) @(posedge clock);
			bus(1'b1, REG_CTRL, 32'h2);
			poll(3'h5);
		end
		// divider from two to thirty poles
		bus(1'b1, REG_CTRL, 32'h1);
		poll(3'h0);
		foreach (divs[j]) begin
			bus(1'b1, REG_TACHCFG, {28'h0, divs[j]});
			tach_gap(32'(divs[j]) + 32'h1);
		end
		motor_lock <= 1'b1;
		repeat (4) @(posedge clock);
		chk(3'h3, 32'h1);
		motor_lock <= 1'b0;
		open_loop <= 1'b1;
		bus(1'b1, REG_TACHCFG, {25'h0, OLP_HIGH, 5'h02});
		repeat (4) @(posedge clock);
		chk(3'h3, 32'h1);
		bus(1'b1, REG_TACHCFG, {25'h0, OLP_FOLLOW, 5'h02});
		tach_gap(32'h3);
		bus(1'b1, REG_TACHCFG, {25'h0, OLP_FIRST, 5'h02});
		repeat (4) @(posedge clock);
		chk(3'h3, 32'h1);
		open_loop <= 1'b0;
		// persist: tach runs on while the rotor coasts
		bus(1'b1, REG_TACHCFG, 32'h0000_0010);
		bus(1'b1, REG_CTRL, 32'h2);
		poll(3'h5);
		tach_gap(32'h1);
		bus(1'b1, REG_CTRL, 32'h1);
		poll(3'h0);
		// estimate far above cap, flag raised then dropped
		phase_current <= 16'h0100 + 16'($urandom_range(255));
		phase_voltage <= 16'h0100;
		supply_voltage <= 16'h0010;
		bus(1'b1, REG_CAP, 32'h8000_0001);
		repeat (150) @(posedge clock);
		rd(REG_STATUS, 32'h80, 32'h80);
		rd(REG_SPEED, 32'h0, ALL);
		bus(1'b1, REG_CAP, 32'h0);
		repeat (8) @(posedge clock);
		rd(REG_STATUS, 32'h0, 32'h80);
		rd(REG_SPEED, {16'h0, speed_cmd}, ALL);
		// persist with floor above rotor: tach quiet once stopped
		bus(1'b1, REG_TACHCFG, 32'h0000_FF10);
		bus(1'b1, REG_CTRL, 32'h2);
		poll(3'h5);
		chk(3'h3, 32'h0);
		stop_test();
	end
endmodule : tb_top

`default_nettype wire
